// ---- shared/twes_defines.svh ----
`ifndef TWES_DEFINES_SVH
`define TWES_DEFINES_SVH

// Widths of the parallel word, its bytes, one code character and the serial word.
`define TWES_WORD_W      16
`define TWES_BYTE_W      8
`define TWES_CHAR_W      10
`define TWES_SER_W       20
`define TWES_PHASE_W     5

// Bit clock ratio to the word clock; the serializer shifts on both of its edges.
`define TWES_CLK_MULT    10

// Phase within the word period at which a held word enters the shift register.
`define TWES_LOAD_PHASE  5'h0f

// Transmit latency window in bit times, and the figure this design achieves.
`define TWES_LAT_MIN     34
`define TWES_LAT_MAX     38
`define TWES_LAT_BITS    36

// Idle words forced out after reset so the far end can find byte boundaries.
`define TWES_START_WORDS 3

// Byte values of the control and idle characters.
`define TWES_K28_5       8'hbc
`define TWES_D5_6        8'hc5
`define TWES_D16_2       8'h50
`define TWES_K23_7       8'hf7
`define TWES_K30_7       8'hfe

// K28.5 as sent, first bit in bit 0, for negative and positive running disparity.
`define TWES_COMMA_NEG   10'h17c
`define TWES_COMMA_POS   10'h283

`endif

// ---- shared/twes_pkg.sv ----
package twes_pkg;

    typedef struct packed {
        logic [15:0] data;
        logic        frame_valid;
        logic        tx_error_code;
    } twes_word_t;

    typedef struct packed {
        logic [7:0] byte_val;
        logic       is_k;
    } twes_sym_t;

    typedef enum logic [1:0] {
        TWES_IDLE = 2'b00,
        TWES_CEXT = 2'b01,
        TWES_DATA = 2'b10,
        TWES_ERRP = 2'b11
    } twes_mode_t;

    typedef enum logic {
        TWES_ALIGN = 1'b0,
        TWES_RUN   = 1'b1
    } twes_state_t;

endpackage

// ---- rtl/twes_enc_8b10b.sv ----
`include "twes_defines.svh"

// One 8b/10b character encoder; the output carries bit a in bit 0 so it is sent first.
module twes_enc_8b10b (
    input  wire logic [7:0] byte_in, // Byte to encode.
    input  wire logic       is_k,    // High for a control character.
    input  wire logic       rd_in,   // Running disparity before, high is positive.
    output logic      [9:0] code,    // Encoded character.
    output logic            rd_out   // Running disparity after.
);

    logic [4:0] x;
    logic [2:0] y;
    logic [5:0] s6;
    logic [3:0] s4;
    logic [5:0] c6;
    logic [3:0] c4;
    logic [9:0] msb_first;
    logic       rd_mid;
    logic       k28;
    logic       a7;

    assign x   = byte_in[4:0];
    assign y   = byte_in[7:5];
    assign k28 = is_k && (x == 5'h1c);

    always_comb begin
        unique case (x)
            5'h00: s6 = 6'h27;  5'h01: s6 = 6'h1d;  5'h02: s6 = 6'h2d;  5'h03: s6 = 6'h31;
            5'h04: s6 = 6'h35;  5'h05: s6 = 6'h29;  5'h06: s6 = 6'h19;  5'h07: s6 = 6'h38;
            5'h08: s6 = 6'h39;  5'h09: s6 = 6'h25;  5'h0a: s6 = 6'h15;  5'h0b: s6 = 6'h34;
            5'h0c: s6 = 6'h0d;  5'h0d: s6 = 6'h2c;  5'h0e: s6 = 6'h1c;  5'h0f: s6 = 6'h17;
            5'h10: s6 = 6'h1b;  5'h11: s6 = 6'h23;  5'h12: s6 = 6'h13;  5'h13: s6 = 6'h32;
            5'h14: s6 = 6'h0b;  5'h15: s6 = 6'h2a;  5'h16: s6 = 6'h1a;  5'h17: s6 = 6'h3a;
            5'h18: s6 = 6'h33;  5'h19: s6 = 6'h26;  5'h1a: s6 = 6'h16;  5'h1b: s6 = 6'h36;
            5'h1c: s6 = 6'h0e;  5'h1d: s6 = 6'h2e;  5'h1e: s6 = 6'h1e;  5'h1f: s6 = 6'h2b;
        endcase
        if (k28) begin
            s6 = 6'h0f;
        end
        // Unbalanced blocks, and D.7 whose two forms differ, invert under positive disparity.
        c6     = (rd_in && (($countones(s6) != 3) || (x == 5'h07))) ? ~s6 : s6;
        rd_mid = rd_in ^ ($countones(s6) != 3);
        // The alternate x.7 form avoids a run of five equal bits across the block edge.
        a7 = (y == 3'h7) && (is_k || (!rd_mid && (x == 5'h11 || x == 5'h12 || x == 5'h14))
                                  || (rd_mid && (x == 5'h0b || x == 5'h0d || x == 5'h0e)));
        unique case (y)
            3'h0: s4 = 4'hb;  3'h1: s4 = 4'h9;  3'h2: s4 = 4'h5;  3'h3: s4 = 4'hc;
            3'h4: s4 = 4'hd;  3'h5: s4 = 4'ha;  3'h6: s4 = 4'h6;  3'h7: s4 = 4'he;
        endcase
        if (a7) begin
            s4 = 4'h7;
        end
        if (y == 3'h0 || y == 3'h3 || y == 3'h4 || y == 3'h7) begin
            c4 = rd_mid ? ~s4 : s4;
        end else begin
            c4 = (k28 && !rd_mid) ? ~s4 : s4;
        end
        rd_out    = rd_mid ^ ($countones(c4) != 2);
        msb_first = {c6, c4};
        for (int i = 0; i < `TWES_CHAR_W; i++) begin
            code[i] = msb_first[`TWES_CHAR_W - 1 - i];
        end
    end

endmodule

// ---- rtl/twes_tx_serializer.sv ----
`include "twes_defines.svh"

// How it works
// - Capture the 16-bit word and both controls on each rising word clock edge.
// - Bit clock is ten times the word clock; shifting on both edges gives twenty.
// - The least significant bit of each word leaves the serial output first.
// - After reset, idle words with commas go out before any payload.
// - Each word splits into two bytes, each through its own 10-bit encoder.
// - Frame valid high, error low: both bytes go out as data characters.
// - Frame valid low, error high: carrier extend, two K23.7 characters.
// - Frame valid and error both high: error propagation, two K30.7 characters.
// - Running disparity is tracked so the line stays DC balanced.
// - Word load to bit 0 on the line is fixed, between 34 and 38 bit times.
// - Both controls low: idle, K28.5 then D5.6 or D16.2.
// - Negative-disparity K28.5 is 0011111010, its first seven bits the comma.
module twes_tx_serializer #(
    parameter int unsigned START_WORDS = `TWES_START_WORDS // Idle words after reset.
) (
    input  wire logic                clk,           // Serial rate clock, one bit time.
    input  wire logic                rst,           // Synchronous reset, active high.
    input  wire logic                tx_word_clock, // Word clock from the protocol device.
    input  wire twes_pkg::twes_word_t tx_word,      // Word with frame valid and error code.
    output logic                     bit_clk,       // Derived bit clock, 10x word rate.
    output logic                     serial_out,    // Serial data, first bit first.
    output logic                     link_ready     // High once start-up idles are encoded.
);

    localparam int unsigned CW = $clog2(START_WORDS + 1);

    logic                      word_clk_prev;
    logic                      word_edge;
    twes_pkg::twes_word_t      cap;
    logic                      cap_pulse;
    logic [`TWES_PHASE_W-1:0]  phase;
    logic                      load_now;
    twes_pkg::twes_state_t     state;
    logic [CW-1:0]             start_left;
    twes_pkg::twes_mode_t      mode;
    twes_pkg::twes_sym_t       sym_lo;
    twes_pkg::twes_sym_t       sym_hi;
    logic [`TWES_CHAR_W-1:0]   code_lo;
    logic [`TWES_CHAR_W-1:0]   code_hi;
    logic                      rd;
    logic                      rd_mid;
    logic                      next_rd;
    logic [`TWES_SER_W-1:0]    enc;
    logic [`TWES_SER_W-1:0]    held;
    logic [`TWES_SER_W-1:0]    shreg;

    // The word clock is sampled by clk; inputs are synchronous to it.
    assign word_edge = tx_word_clock && !word_clk_prev;

    always_ff @(posedge clk) begin
        if (rst) begin
            word_clk_prev <= 1'b0;
        end else begin
            word_clk_prev <= tx_word_clock;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cap       <= '0;
            cap_pulse <= 1'b0;
        end else begin
            cap_pulse <= word_edge;
            if (word_edge) begin
                cap <= tx_word;
            end
        end
    end

    // The phase counter and bit clock realign on every word edge, so a word clock
    // that drifts against clk slips a whole bit rather than tearing a character.
    always_ff @(posedge clk) begin
        if (rst) begin
            phase   <= '0;
            bit_clk <= 1'b0;
        end else if (word_edge) begin
            phase   <= '0;
            bit_clk <= 1'b1;
        end else begin
            phase   <= (phase == `TWES_PHASE_W'(`TWES_SER_W - 1)) ? '0 : phase + 1'b1;
            bit_clk <= ~bit_clk;
        end
    end

    assign load_now = (phase == `TWES_LOAD_PHASE);

    always_ff @(posedge clk) begin
        if (rst) begin
            state      <= twes_pkg::TWES_ALIGN;
            start_left <= CW'(START_WORDS);
        end else if (cap_pulse && state == twes_pkg::TWES_ALIGN) begin
            start_left <= start_left - 1'b1;
            if (start_left <= CW'(1)) begin
                state <= twes_pkg::TWES_RUN;
            end
        end
    end

    assign link_ready = (state == twes_pkg::TWES_RUN);

    always_comb begin
        // Payload is held off until the start-up commas are out.
        mode = (state == twes_pkg::TWES_ALIGN) ? twes_pkg::TWES_IDLE
             : twes_pkg::twes_mode_t'({cap.frame_valid, cap.tx_error_code});
        unique case (mode)
            twes_pkg::TWES_IDLE: begin
                sym_lo = '{`TWES_K28_5, 1'b1};
                // D16.2 flips disparity back to negative; D5.6 keeps it negative.
                sym_hi = '{(rd ? `TWES_D5_6 : `TWES_D16_2), 1'b0};
            end
            twes_pkg::TWES_CEXT: begin
                sym_lo = '{`TWES_K23_7, 1'b1};
                sym_hi = '{`TWES_K23_7, 1'b1};
            end
            twes_pkg::TWES_DATA: begin
                sym_lo = '{cap.data[7:0], 1'b0};
                sym_hi = '{cap.data[15:8], 1'b0};
            end
            twes_pkg::TWES_ERRP: begin
                sym_lo = '{`TWES_K30_7, 1'b1};
                sym_hi = '{`TWES_K30_7, 1'b1};
            end
        endcase
    end

    twes_enc_8b10b u_enc_lo (
        .byte_in (sym_lo.byte_val),
        .is_k    (sym_lo.is_k),
        .rd_in   (rd),
        .code    (code_lo),
        .rd_out  (rd_mid)
    );

    twes_enc_8b10b u_enc_hi (
        .byte_in (sym_hi.byte_val),
        .is_k    (sym_hi.is_k),
        .rd_in   (rd_mid),
        .code    (code_hi),
        .rd_out  (next_rd)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            rd  <= 1'b0;
            enc <= '0;
        end else if (cap_pulse) begin
            rd  <= next_rd;
            enc <= {code_hi, code_lo};
        end
    end

    // A second word of storage keeps the latency fixed at one full word period
    // plus the load phase, independent of when encoding finishes.
    always_ff @(posedge clk) begin
        if (rst) begin
            held <= '0;
        end else if (word_edge) begin
            held <= enc;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            shreg <= '0;
        end else if (load_now) begin
            shreg <= held;
        end else begin
            shreg <= {1'b0, shreg[`TWES_SER_W-1:1]};
        end
    end

    assign serial_out = shreg[0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_capture_word: assert property (word_edge |=> cap_pulse && cap == $past(tx_word))
        else $error("word not captured on word clock edge");
    chk_bit_clock: assert property (word_edge |=> bit_clk ##1 !bit_clk ##1 bit_clk)
        else $error("bit clock not toggling from word edge");
    chk_lsb_first: assert property (load_now |=> serial_out == $past(held[0])
                                    ##1 serial_out == $past(held[1], 2))
        else $error("serial order not lsb first");
    chk_start_idle: assert property (state == twes_pkg::TWES_ALIGN |-> sym_lo.is_k
                                     && sym_lo.byte_val == `TWES_K28_5)
        else $error("payload sent before start commas");
    chk_start_exit: assert property (cap_pulse && state == twes_pkg::TWES_ALIGN
                                     && start_left == CW'(1) |=> link_ready)
        else $error("start-up idle phase did not end");
    chk_byte_split: assert property (mode == twes_pkg::TWES_DATA |-> sym_lo.byte_val
                                     == cap.data[7:0] && sym_hi.byte_val == cap.data[15:8])
        else $error("bytes not split low then high");
    chk_data_chars: assert property (cap.frame_valid && !cap.tx_error_code && link_ready
                                     |-> !sym_lo.is_k && !sym_hi.is_k)
        else $error("data word sent as control");
    chk_carrier_ext: assert property (!cap.frame_valid && cap.tx_error_code && link_ready
                                      |-> sym_hi == twes_pkg::twes_sym_t'{`TWES_K23_7, 1'b1})
        else $error("carrier extend not K23.7");
    chk_error_prop: assert property (cap.frame_valid && cap.tx_error_code && link_ready
                                     |-> sym_lo == twes_pkg::twes_sym_t'{`TWES_K30_7, 1'b1})
        else $error("error propagation not K30.7");
    chk_disparity: assert property (cap_pulse |-> $countones(code_lo) == 5
                                    || $countones(code_lo) == (rd ? 4 : 6))
        else $error("character breaks running disparity");
    chk_latency: assert property (cap_pulse |-> ##35 load_now)
        else $error("transmit latency not fixed");
    chk_idle_pair: assert property (mode == twes_pkg::TWES_IDLE |-> sym_hi.byte_val
                                    == (rd ? `TWES_D5_6 : `TWES_D16_2))
        else $error("wrong idle second character");
    chk_comma_code: assert property (sym_lo == twes_pkg::twes_sym_t'{`TWES_K28_5, 1'b1} |-> code_lo
                                     == (rd ? `TWES_COMMA_POS : `TWES_COMMA_NEG))
        else $error("K28.5 pattern wrong");
    chk_rd_carry: assert property (cap_pulse |-> rd_mid
                                   == (rd ^ ($countones(code_lo) != 5)))
        else $error("disparity not carried between bytes");

    cov_data_word: cover property (cap_pulse && mode == twes_pkg::TWES_DATA);
    cov_carrier: cover property (cap_pulse && mode == twes_pkg::TWES_CEXT);
    cov_error: cover property (cap_pulse && mode == twes_pkg::TWES_ERRP);
    cov_link_up: cover property ($rose(link_ready));

endmodule

// ---- bench/twes_proto_model.sv ----
// Protocol device model: a free-running word clock of 20 bit times, a word on each rising edge.
module twes_proto_model (
    input  wire logic                 clk,           // Bench clock, one bit time.
    input  wire logic                 rst,           // Holds the word clock low.
    input  wire logic                 next_vld,      // A bench word is waiting.
    input  wire twes_pkg::twes_word_t next_word,     // The waiting word.
    output logic                      tx_word_clock, // Word clock to the block.
    output twes_pkg::twes_word_t      tx_word,       // Word presented to the block.
    output logic                      took           // High for one cycle when the word went out.
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned phase;
    initial begin
        phase = 0;
        tx_word_clock = 1'b0;
        tx_word = '0;
        took = 1'b0;
    end
    always @(negedge clk) begin
        took = 1'b0;
        if (rst) begin
            phase = 0;
            tx_word_clock = 1'b0;
        end else begin
            if (phase == 0) begin
                tx_word_clock = 1'b1;
                // With no bench word, frame valid is low at the word edge between frames.
                tx_word = next_vld ? next_word : twes_pkg::twes_word_t'({~tx_word.data, 2'b00});
                took = next_vld;
            end else if (phase == 1) begin
                // The word is not held past its edge, so a late capture sees garbage.
                tx_word = ~tx_word;
            end
            if (phase == 10) tx_word_clock = 1'b0;
            phase = (phase == 19) ? 0 : phase + 1;
        end
    end
endmodule

// ---- bench/test_tx_word_encoder_serializer.sv ----
module test_tx_word_encoder_serializer;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned START = 2;
    logic                 clk, rst, next_vld, tx_word_clock, took, bit_clk, serial_out, link_ready;
    logic                 rd, bclk_prev, twc_prev;
    logic [31:0]          seed;
    logic [19:0]          sr;
    twes_pkg::twes_word_t next_word, tx_word;
    int                   num_errors, tests_run, cyc, idx, c_last;
    logic [1:0]           q_mode[$];
    logic [15:0]          q_data[$];
    int                   q_due[$];

    twes_tx_serializer #(.START_WORDS(START)) dut (.clk(clk), .rst(rst),
        .tx_word_clock(tx_word_clock), .tx_word(tx_word), .bit_clk(bit_clk),
        .serial_out(serial_out), .link_ready(link_ready));
    twes_proto_model partner (.clk(clk), .rst(rst), .next_vld(next_vld), .next_word(next_word),
        .tx_word_clock(tx_word_clock), .tx_word(tx_word), .took(took));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    function automatic logic [31:0] xorshift(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // Codes are written in sent order, first bit leftmost, then turned so bit 0 goes first.
    function automatic logic [10:0] exp_char(input logic [1:0] m, input logic hi,
                                             input logic [7:0] b, input logic r, input logic rw);
        logic [9:0] n, p, v;
        n = 10'h000;
        p = 10'h000;
        case (m)
            twes_pkg::TWES_IDLE: begin
                if (!hi) begin n = 10'b0011111010; p = 10'b1100000101; end
                else if (rw) begin n = 10'b1010010110; p = 10'b1010010110; end
                else begin n = 10'b0110110101; p = 10'b1001000101; end
            end
            twes_pkg::TWES_CEXT: begin n = 10'b1110101000; p = 10'b0001010111; end
            twes_pkg::TWES_ERRP: begin n = 10'b0111101000; p = 10'b1000010111; end
            default: begin
                if (b != 8'h00) return 11'h000;
                n = 10'b1001110100;
                p = 10'b0110001011;
            end
        endcase
        for (int i = 0; i < 10; i++) v[i] = r ? p[9-i] : n[9-i];
        return {1'b1, v};
    endfunction

    task automatic check(input logic [19:0] got, input logic [19:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Nonzero data bytes are only judged on disparity; known codes are compared whole.
    task automatic check_char(input logic [9:0] got, input logic [1:0] m, input logic hi,
                              input logic [7:0] b, input logic rw);
        logic [10:0] e;
        e = exp_char(m, hi, b, rd, rw);
        if (e[10]) check({10'h000, got}, {10'h000, e[9:0]});
        else check({19'h0, ($countones(got) == 5) || ($countones(got) == (rd ? 4 : 6))},
                   20'h1);
        if ($countones(got) != 5) rd = ~rd;
    endtask

    always @(posedge clk) begin
        if (rst) begin
            q_mode.delete();
            q_data.delete();
            q_due.delete();
            idx = 0;
            rd = 1'b0;
            c_last = -1;
        end else if (tx_word_clock && !twc_prev) begin
            q_mode.push_back(idx < START ? twes_pkg::TWES_IDLE
                             : {tx_word.frame_valid, tx_word.tx_error_code});
            q_data.push_back(tx_word.data);
            q_due.push_back(cyc + 56);
            c_last = cyc;
            idx++;
        end
        twc_prev = tx_word_clock;
        cyc = cyc + 1;
    end

    always @(negedge clk) begin
        logic rw;
        sr = {serial_out, sr[19:1]};
        if (!rst && c_last >= 0 && cyc == c_last + 1) check({19'h0, bit_clk}, 20'h1);
        else if (!rst && c_last >= 0) check({19'h0, bit_clk}, {19'h0, ~bclk_prev});
        bclk_prev = bit_clk;
        if (q_due.size() > 0 && cyc == q_due[0]) begin
            rw = rd;
            check_char(sr[9:0], q_mode[0], 1'b0, q_data[0][7:0], rw);
            check_char(sr[19:10], q_mode[0], 1'b1, q_data[0][15:8], rw);
            void'(q_mode.pop_front());
            void'(q_data.pop_front());
            void'(q_due.pop_front());
        end
    end

    task automatic put(input logic [15:0] d, input logic fv, input logic er);
        int n;
        n = 0;
        @(negedge clk);
        next_word <= '{data: d, frame_valid: fv, tx_error_code: er};
        next_vld <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (!took && n < 100);
        @(negedge clk);
        next_vld <= 1'b0;
    endtask

    function automatic logic [15:0] rnd_data(input logic [31:0] s);
        return s[15:0] & {s[16] ? 8'hff : 8'h00, s[17] ? 8'hff : 8'h00};
    endfunction

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        #300us;
        num_errors++;
        $display("unexpected at %0t: got %h expected %h", $time, 32'h0, 32'h1);
        results();
    end

    initial begin
        int len;
        rst = 1'b1;
        next_vld = 1'b0;
        next_word = '0;
        seed = 32'h28;
        {num_errors, tests_run, cyc, idx, c_last} = '0;
        {rd, bclk_prev, twc_prev, sr} = '0;
        repeat (12) @(negedge clk);
        rst <= 1'b0;
        check({19'h0, link_ready}, 20'h0);
        for (int i = 0; i < START + 2; i++) put(16'h1234, 1'b1, 1'b0);
        repeat (60) @(negedge clk);
        check({19'h0, link_ready}, 20'h1);
        $display("test startup done");
        for (int m = 0; m < 4; m++) begin
            for (int k = 0; k < 3; k++) begin
                seed = xorshift(seed);
                put(k == 0 ? 16'h0000 : seed[15:0], m[1], m[0]);
            end
        end
        $display("test modes done");
        for (int f = 0; f < 40; f++) begin
            seed = xorshift(seed);
            len = 1 + seed[7:0] % 6;
            for (int i = 0; i < len; i++) begin
                seed = xorshift(seed);
                put(rnd_data(seed), 1'b1, seed[20:18] == 3'h0);
            end
            seed = xorshift(seed);
            if (seed[0]) put(16'hf7f7, 1'b0, 1'b1);
        end
        repeat (60) @(negedge clk);
        $display("test frames done");
        put(16'h00ff, 1'b1, 1'b0);
        put(16'hff00, 1'b1, 1'b1);
        rst <= 1'b1;
        repeat (12) @(negedge clk);
        check({18'h0, serial_out, link_ready}, 20'h0);
        rst <= 1'b0;
        for (int i = 0; i < START + 3; i++) put(16'h0000, 1'b1, 1'b0);
        repeat (60) @(negedge clk);
        $display("test reset done");
        results();
    end
endmodule
